// ---- pkg/spif_pkg.sv ----
package spif_pkg;
  localparam logic [7:0] REQ_START = 8'h50;
  localparam logic [7:0] RSP_START = 8'h70;
  localparam int IMG_WORDS = 8;
  localparam int IDX_W = 3;
  localparam int CLK_HZ = 125000000;
  localparam int BAUD = 38400;
  localparam int BIT_CYC = CLK_HZ / BAUD;
  localparam int CNT_W = 12;
  localparam logic [CNT_W-1:0] BIT_CNT = CNT_W'(BIT_CYC - 1);
  localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(BIT_CYC / 2 - 1);
  localparam int ST_IOERR = 0;
  localparam int ST_CFGERR = 1;
  localparam int ST_LENERR = 4;
  localparam logic [7:0] MASTER_ADDR = 8'h00;
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_IRQST = 32'h0000_0008;
  localparam logic [31:0] ADDR_IRQMSK = 32'h0000_000c;
  localparam logic [31:0] ADDR_OUTIMG = 32'h0000_0040;
  localparam logic [31:0] ADDR_INIMG = 32'h0000_0080;
  localparam logic [3:0] IRQ_RESET = 4'h0;
  typedef enum logic [3:0] {
    RX_START = 4'h1,
    RX_HDR = 4'h2,
    RX_DATA = 4'h4,
    RX_SUM = 4'h8
  } spif_rx_t;
endpackage : spif_pkg

// ---- hdl/spif_framer.sv ----
`timescale 1ns/1ns
// Behaviour
// - every byte uses eight data bits, even parity, one stop bit
// - bit rate defaults to 38400 baud
// - station address from two decimal switches; zero means master
// - each request carrying outputs gets one response with status and inputs
// - request starts with byte 0x50
// - response echoes received message identifier unchanged
// - data words sent low byte first
// - checksum is modulo-256 sum of all preceding bytes
// - response: 0x70, count, ident, address, status, inputs, checksum
// - status bit 0 on io comm error, bit 1 on config error
// - status bit 4 when received count differs from image size
// - each transaction moves the complete input image; the output image only when the count matches
module spif_framer #(
  parameter int BIT_CYC = spif_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rxd,
  output logic txd,
  output logic txEn,
  input wire logic [3:0] addrTens,
  input wire logic [3:0] addrOnes,
  input wire logic ioCommErr,
  input wire logic cfgErr,
  output logic masterMode,
  output logic irq,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  localparam int N = spif_pkg::IMG_WORDS;
  // bit timing follows the instance's bit time, package value by default
  localparam logic [11:0] BIT_CNT_C = 12'(BIT_CYC - 1);
  localparam logic [11:0] HALF_CNT_C = 12'(BIT_CYC / 2 - 1);
  localparam logic [3:0] IRQ_RESET_C = spif_pkg::IRQ_RESET;

  ////////////////////////////////////////////////////////////////////////
  // pin sync and station address
  logic [2:0] rxSync_r;
  logic [7:0] station_r;
  always_ff @(posedge clk) begin
    if (!resetn) rxSync_r <= 3'h7;
    else rxSync_r <= {rxSync_r[1:0], rxd};
  end
  logic [3:0] tensA_r, onesA_r, tensB_r, onesB_r;
  // no reset: the switches refill the station within three clocks
  always_ff @(posedge clk) begin
    tensA_r <= addrTens;
    onesA_r <= addrOnes;
    tensB_r <= tensA_r;
    onesB_r <= onesA_r;
    station_r <= 8'({4'h0, tensB_r} * 8'h0a) + {4'h0, onesB_r};
  end
  assign masterMode = (station_r == spif_pkg::MASTER_ADDR);
  logic rxIn;
  assign rxIn = rxSync_r[2];

  ////////////////////////////////////////////////////////////////////////
  // uart receiver, 8E1
  logic [11:0] rxCnt_r;
  logic [3:0] rxBit_r;
  logic [8:0] rxSh_r;
  logic rxBusy_r, rxByte_r, rxPerr_r;
  logic [7:0] rxData_r;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxBusy_r <= 1'b0;
      rxCnt_r <= '0;
      rxBit_r <= '0;
      rxSh_r <= '0;
      rxByte_r <= 1'b0;
      rxPerr_r <= 1'b0;
      rxData_r <= '0;
    end else begin
      rxByte_r <= 1'b0;
      if (!rxBusy_r) begin
        if (!rxIn) begin
          rxBusy_r <= 1'b1;
          rxCnt_r <= HALF_CNT_C;
          rxBit_r <= '0;
        end
      end else if (rxCnt_r != '0) begin
        rxCnt_r <= rxCnt_r - 12'h001;
      end else begin
        rxCnt_r <= BIT_CNT_C;
        rxBit_r <= rxBit_r + 4'h1;
        // line high again at mid start bit: a glitch, not a start
        if (rxBit_r == 4'h0 && rxIn) rxBusy_r <= 1'b0;
        else if (rxBit_r >= 4'h1 && rxBit_r <= 4'h9) rxSh_r <= {rxIn, rxSh_r[8:1]};
        else if (rxBit_r == 4'ha) begin
          rxBusy_r <= 1'b0;
          // a low stop bit drops the byte
          rxByte_r <= rxIn;
          rxData_r <= rxSh_r[7:0];
          rxPerr_r <= ^rxSh_r;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request parser
  spif_pkg::spif_rx_t rxSt_r;
  logic [1:0] hdrIdx_r;
  logic [7:0] cnt_r, ident_r, dest_r, sum_r, bytesLeft_r;
  logic [8:0] dataIdx_r;
  logic bad_r, lowPh_r;
  logic [7:0] lowByte_r;
  logic [15:0] stage_r [N];
  logic [15:0] outImg_r [N];
  logic reqOk, reqDrop;
  // checksum byte in: the whole request is accepted or dropped here
  assign reqOk = rxByte_r && rxSt_r == spif_pkg::RX_SUM && !rxPerr_r && !bad_r
    && rxData_r == sum_r && dest_r == station_r && !masterMode;
  assign reqDrop = rxByte_r && rxSt_r == spif_pkg::RX_SUM && !reqOk;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rxSt_r <= spif_pkg::RX_START;
      hdrIdx_r <= '0;
      cnt_r <= '0;
      ident_r <= '0;
      dest_r <= '0;
      sum_r <= '0;
      dataIdx_r <= '0;
      bad_r <= 1'b0;
      lowPh_r <= 1'b1;
      lowByte_r <= '0;
    end else if (rxByte_r) begin
      sum_r <= sum_r + rxData_r;
      if (rxPerr_r) bad_r <= 1'b1;
      unique case (rxSt_r)
        spif_pkg::RX_START: begin
          sum_r <= rxData_r;
          bad_r <= rxPerr_r;
          if (rxData_r == spif_pkg::REQ_START && !rxPerr_r) begin
            rxSt_r <= spif_pkg::RX_HDR;
            hdrIdx_r <= 2'h0;
          end
        end
        spif_pkg::RX_HDR: begin
          hdrIdx_r <= hdrIdx_r + 2'h1;
          if (hdrIdx_r == 2'h0) cnt_r <= rxData_r;
          if (hdrIdx_r == 2'h1) ident_r <= rxData_r;
          if (hdrIdx_r == 2'h2) begin
            dest_r <= rxData_r;
            dataIdx_r <= '0;
            lowPh_r <= 1'b1;
            rxSt_r <= (cnt_r == 8'h00) ? spif_pkg::RX_SUM : spif_pkg::RX_DATA;
          end
        end
        spif_pkg::RX_DATA: begin
          lowPh_r <= !lowPh_r;
          if (lowPh_r) lowByte_r <= rxData_r;
          else begin
            if (dataIdx_r < 9'(N)) stage_r[dataIdx_r[spif_pkg::IDX_W-1:0]] <= {rxData_r, lowByte_r};
            dataIdx_r <= dataIdx_r + 9'h001;
            if (dataIdx_r + 9'h001 == {1'b0, cnt_r}) rxSt_r <= spif_pkg::RX_SUM;
          end
        end
        spif_pkg::RX_SUM: rxSt_r <= spif_pkg::RX_START;
      endcase
    end
  end

  // outputs commit only on a fully validated request
  always_ff @(posedge clk) begin
    if (!resetn) begin
      for (int i = 0; i < N; i++) outImg_r[i] <= '0;
    end else if (reqOk && cnt_r == 8'(N)) begin
      for (int i = 0; i < N; i++) outImg_r[i] <= stage_r[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // response builder and uart transmitter
  logic [15:0] inImg_r [N];
  logic [7:0] status_r, txSum_r, txByte;
  logic [8:0] txIdx_r;
  logic txAct_r, txLoad_r, txDone;
  logic [11:0] txCnt_r;
  logic [3:0] txBit_r;
  logic [10:0] txSh_r;
  logic [8:0] txLast;
  assign txLast = 9'(5 + 2 * N);
  always_comb begin
    txByte = 8'h00;
    if (txIdx_r == 9'h000) txByte = spif_pkg::RSP_START;
    else if (txIdx_r == 9'h001) txByte = 8'(N);
    else if (txIdx_r == 9'h002) txByte = ident_r;
    else if (txIdx_r == 9'h003) txByte = station_r;
    else if (txIdx_r == 9'h004) txByte = status_r;
    else if (txIdx_r == txLast) txByte = txSum_r;
    else if (txIdx_r[0]) txByte = inImg_r[3'((txIdx_r - 9'h005) >> 1)][7:0];
    else txByte = inImg_r[3'((txIdx_r - 9'h005) >> 1)][15:8];
  end
  assign txDone = txAct_r && !txLoad_r && txCnt_r == '0 && txBit_r == 4'ha;
  // answer starts inside the request's stop bit; one load cycle per byte
  always_ff @(posedge clk) begin
    if (!resetn) begin
      txAct_r <= 1'b0;
      txLoad_r <= 1'b0;
      txIdx_r <= '0;
      txSum_r <= '0;
      status_r <= '0;
      txCnt_r <= '0;
      txBit_r <= '0;
      txSh_r <= '1;
    end else if (!txAct_r) begin
      if (reqOk) begin
        txAct_r <= 1'b1;
        txLoad_r <= 1'b1;
        txIdx_r <= '0;
        txSum_r <= '0;
        status_r <= 8'h00;
        status_r[spif_pkg::ST_IOERR] <= ioCommErr;
        status_r[spif_pkg::ST_CFGERR] <= cfgErr;
        // wrong count is still answered, outputs are kept
        status_r[spif_pkg::ST_LENERR] <= (cnt_r != 8'(N));
      end
    end else if (txLoad_r) begin
      txLoad_r <= 1'b0;
      txSh_r <= {1'b1, ^txByte, txByte, 1'b0};
      txSum_r <= txSum_r + txByte;
      txCnt_r <= BIT_CNT_C;
      txBit_r <= '0;
    end else if (txCnt_r != '0) begin
      txCnt_r <= txCnt_r - 12'h001;
    end else if (txBit_r == 4'ha) begin
      txIdx_r <= txIdx_r + 9'h001;
      if (txIdx_r == txLast) txAct_r <= 1'b0;
      else txLoad_r <= 1'b1;
    end else begin
      txCnt_r <= BIT_CNT_C;
      txBit_r <= txBit_r + 4'h1;
      txSh_r <= {1'b1, txSh_r[10:1]};
    end
  end
  // shifter idles on the last stop bit, so the pin comes straight from it
  assign txd = txSh_r[0];
  assign txEn = txAct_r;

  ////////////////////////////////////////////////////////////////////////
  // interrupts: 0 request ok, 1 request dropped, 2 response sent, 3 length
  logic [3:0] irqSt_r, irqMsk_r, irqEv;
  assign irqEv = {reqOk && cnt_r != 8'(N), txDone && txIdx_r == txLast, reqDrop, reqOk};
  logic wrGo, awHeld_r, wHeld_r;
  logic [31:0] awA_r, wD_r;
  logic [31:0] wA, wD;
  assign wA = awHeld_r ? awA_r : awaddr;
  assign wD = wHeld_r ? wD_r : wdata;
  assign wrGo = (awHeld_r || awvalid) && (wHeld_r || wvalid) && !bvalid;
  assign awready = !awHeld_r && !bvalid;
  assign wready = !wHeld_r && !bvalid;
  // a new event wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) irqSt_r <= spif_pkg::IRQ_RESET;
    else if (wrGo && wA == spif_pkg::ADDR_IRQST && wstrb[0])
      irqSt_r <= (irqSt_r & ~wD[3:0]) | irqEv;
    else irqSt_r <= irqSt_r | irqEv;
  end
  assign irq = |(irqSt_r & irqMsk_r);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  always_ff @(posedge clk) begin
    if (!resetn) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awA_r <= '0;
      wD_r <= '0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      irqMsk_r <= IRQ_RESET_C;
      for (int i = 0; i < N; i++) inImg_r[i] <= '0;
    end else begin
      // aw or w arriving alone is parked until its partner comes
      if (awvalid && awready && !wrGo) begin
        awHeld_r <= 1'b1;
        awA_r <= awaddr;
      end
      if (wvalid && wready && !wrGo) begin
        wHeld_r <= 1'b1;
        wD_r <= wdata;
      end
      if (bvalid && bready) bvalid <= 1'b0;
      if (wrGo) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'h0;
        if (wA == spif_pkg::ADDR_IRQMSK) begin
          if (wstrb[0]) irqMsk_r <= wD[3:0];
        end else if (wA[31:5] == spif_pkg::ADDR_INIMG[31:5]) begin
          if (wstrb[0]) inImg_r[wA[4:2]][7:0] <= wD[7:0];
          if (wstrb[1]) inImg_r[wA[4:2]][15:8] <= wD[15:8];
        end else if (wA != spif_pkg::ADDR_IRQST) bresp <= 2'h2;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= 2'h0;
    end else if (rvalid) begin
      if (rready) rvalid <= 1'b0;
    end else if (arvalid) begin
      rvalid <= 1'b1;
      rresp <= 2'h0;
      rdata <= '0;
      if (araddr == spif_pkg::ADDR_CTRL) rdata <= {23'h0, masterMode, station_r};
      else if (araddr == spif_pkg::ADDR_STATUS) rdata <= {16'h0, ident_r, status_r};
      else if (araddr == spif_pkg::ADDR_IRQST) rdata <= {28'h0, irqSt_r};
      else if (araddr == spif_pkg::ADDR_IRQMSK) rdata <= {28'h0, irqMsk_r};
      else if (araddr[31:5] == spif_pkg::ADDR_OUTIMG[31:5]) rdata <= {16'h0, outImg_r[araddr[4:2]]};
      else if (araddr[31:5] == spif_pkg::ADDR_INIMG[31:5]) rdata <= {16'h0, inImg_r[araddr[4:2]]};
      else rresp <= 2'h2;
    end
  end
  assign arready = !rvalid;
endmodule : spif_framer

// ---- testbench/spif_checker.sv ----
`timescale 1ns/1ns
module spif_checker #(
  parameter int BIT_CYC = spif_pkg::BIT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rxd,
  input wire logic txd,
  input wire logic txEn,
  input wire logic [3:0] addrTens,
  input wire logic [3:0] addrOnes,
  input wire logic masterMode
);
  localparam int RSP_MIN = 22 * 11 * BIT_CYC - BIT_CYC / 2;
  logic txdQ_r;
  logic [11:0] runLen_r;
  logic [19:0] enLen_r;
  logic zeroSw;
  assign zeroSw = addrTens == 4'h0 && addrOnes == 4'h0;
  // length of the current txd level, saturating
  always_ff @(posedge clk) begin
    txdQ_r <= txd;
    if (!resetn || txd != txdQ_r) runLen_r <= 12'h001;
    else if (runLen_r != 12'hfff) runLen_r <= runLen_r + 12'h001;
  end
  always_ff @(posedge clk) begin
    if (!resetn || !txEn) enLen_r <= 20'h00000;
    else if (enLen_r != 20'hfffff) enLen_r <= enLen_r + 20'h00001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  AST_IDLE_HIGH: assert property (!txEn |-> txd)
    else $error("txd low while not responding");
  AST_BIT_TIME: assert property (txEn && txd != txdQ_r |-> runLen_r >= 12'(BIT_CYC - 2))
    else $error("txd level shorter than one bit");
  AST_MASTER_SET: assert property (zeroSw [*5] |-> masterMode)
    else $error("master mode missing for station zero");
  AST_MASTER_CLR: assert property (!zeroSw [*5] |-> !masterMode)
    else $error("master mode for nonzero station");
  AST_SLAVE_ONLY: assert property ($rose(txEn) |-> !masterMode)
    else $error("response sent in master mode");
  AST_STOP_END: assert property ($fell(txEn) |-> $past(txd))
    else $error("response did not end on a stop bit");
  AST_RSP_LEN: assert property ($fell(txEn) |-> enLen_r >= 20'(RSP_MIN))
    else $error("response shorter than full image");
  AST_RSP_AFTER_REQ: assert property ($rose(txEn) |-> rxd)
    else $error("response started during request");
  cover property ($rose(txEn));
  cover property ($fell(txEn));
  cover property (zeroSw && masterMode);
endmodule : spif_checker
bind spif_framer spif_checker #(.BIT_CYC(BIT_CYC)) u_spif_checker (.clk(clk), .resetn(resetn),
  .rxd(rxd), .txd(txd), .txEn(txEn), .addrTens(addrTens), .addrOnes(addrOnes),
  .masterMode(masterMode));

// ---- testbench/spif_master_model.sv ----
`timescale 1ns/1ns
module spif_master_model #(
  parameter int BIT_CYC = spif_pkg::BIT_CYC
) (
  input wire logic clk,
  output logic rxd,
  input wire logic txd
);
  logic [7:0] rxQ[$];
  logic [9:0] fr;
  logic parOk;
  // own line driven only by sendByte, never by txd: no echo
  initial rxd = 1'b1;
  task automatic sendByte(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ^b, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (BIT_CYC) @(posedge clk);
    end
  endtask : sendByte
  task automatic sendFrame(input logic [7:0] q[$]);
    foreach (q[i]) sendByte(q[i]);
  endtask : sendFrame
  // mid-bit sampling of response characters
  initial begin
    parOk = 1'b1;
    forever begin
      @(negedge txd);
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        fr[i] = txd;
      end
      if (^fr[8:0] !== 1'b0 || fr[9] !== 1'b1) parOk = 1'b0;
      rxQ.push_back(fr[7:0]);
    end
  end
endmodule : spif_master_model

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ns
module tb_top;
  // short bit time keeps the run brief; hardware keeps its 38400 default
  localparam int BIT = 32;
  logic clk, resetn, rxd, txd, txEn, ioCommErr, cfgErr, masterMode, irq;
  logic [3:0] addrTens, addrOnes, wstrb;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] q[$];
  logic [15:0] inW[8], outW[8];
  int err_total = 0, n_tests = 0, cyc = 0;
  spif_framer #(.BIT_CYC(BIT)) u_spif_framer (.clk, .resetn, .rxd, .txd, .txEn, .addrTens,
    .addrOnes,
    .ioCommErr, .cfgErr, .masterMode, .irq, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready);
  spif_master_model #(.BIT_CYC(BIT)) u_spif_master_model (.clk, .rxd, .txd);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  always @(posedge clk) begin
    cyc <= cyc + 1;
    // about twice the expected run length
    if (cyc == 60000) begin
      err_total++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, 32'h0);
  endtask : wr
  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk(rd, e);
  endtask : rdChk
  task automatic sendReq(input logic [7:0] cnt, input logic [7:0] id, input logic bad);
    logic [7:0] s;
    q = {8'h50, cnt, id, 8'h01};
    for (int i = 0; i < int'(cnt); i++) begin
      q.push_back(outW[i][7:0]);
      q.push_back(outW[i][15:8]);
    end
    s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(s ^ {7'h0, bad});
    @(posedge clk);
    u_spif_master_model.sendFrame(q);
  endtask : sendReq
  task automatic chkRsp(input logic [7:0] id, input logic [7:0] st);
    logic [7:0] s;
    q = {8'h70, 8'h08, id, 8'h01, st};
    for (int i = 0; i < 8; i++) begin
      q.push_back(inW[i][7:0]);
      q.push_back(inW[i][15:8]);
    end
    s = 8'h00;
    foreach (q[i]) s += q[i];
    q.push_back(s);
    while (u_spif_master_model.rxQ.size() < q.size()) @(posedge clk);
    foreach (q[i]) chk({24'h0, u_spif_master_model.rxQ[i]}, {24'h0, q[i]});
    chk({31'h0, u_spif_master_model.parOk}, 32'h1);
    u_spif_master_model.rxQ.delete();
    repeat (2 * BIT) @(posedge clk);
  endtask : chkRsp
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready, ioCommErr, cfgErr} = '0;
    {awaddr, wdata, araddr, wstrb} = '0;
    wstrb = 4'hf;
    addrTens = 4'h0;
    addrOnes = 4'h1;
    for (int i = 0; i < 8; i++) begin
      outW[i] = 16'h12c0 + 16'(i * 'h0103);
      inW[i] = 16'h8a05 + 16'(i * 'h0211);
    end
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    rdChk(spif_pkg::ADDR_CTRL, 32'h1);
    addrOnes <= 4'h0;
    repeat (6) @(posedge clk);
    rdChk(spif_pkg::ADDR_CTRL, 32'h100);
    addrOnes <= 4'h1;
    repeat (6) @(posedge clk);
    rdChk(32'h100, 32'h0);
    chk({30'h0, rs}, 32'h2);
    wr(spif_pkg::ADDR_IRQMSK, 32'hf);
    rdChk(spif_pkg::ADDR_IRQMSK, 32'hf);
    for (int i = 0; i < 8; i++) wr(spif_pkg::ADDR_INIMG + 32'(4 * i), {16'h0, inW[i]});
    sendReq(8'h00, 8'h3c, 1'b1);
    repeat (30 * BIT) @(posedge clk);
    chk(32'(u_spif_master_model.rxQ.size()), 32'h0);
    rdChk(spif_pkg::ADDR_IRQST, 32'h2);
    chk({31'h0, irq}, 32'h1);
    wr(spif_pkg::ADDR_IRQST, 32'hf);
    rdChk(spif_pkg::ADDR_IRQST, 32'h0);
    chk({31'h0, irq}, 32'h0);
    addrOnes <= 4'h2;
    repeat (6) @(posedge clk);
    sendReq(8'h00, 8'h3d, 1'b0);
    addrOnes <= 4'h1;
    repeat (15 * BIT) @(posedge clk);
    chk(32'(u_spif_master_model.rxQ.size()), 32'h0);
    rdChk(spif_pkg::ADDR_IRQST, 32'h2);
    wr(spif_pkg::ADDR_IRQST, 32'hf);
    ioCommErr <= 1'b1;
    sendReq(8'h08, 8'ha7, 1'b0);
    chkRsp(8'ha7, 8'h01);
    for (int i = 0; i < 8; i++) rdChk(spif_pkg::ADDR_OUTIMG + 32'(4 * i), {16'h0, outW[i]});
    rdChk(spif_pkg::ADDR_STATUS, 32'ha701);
    rdChk(spif_pkg::ADDR_IRQST, 32'h5);
    wr(spif_pkg::ADDR_IRQST, 32'hf);
    ioCommErr <= 1'b0;
    cfgErr <= 1'b1;
    outW[0] = 16'hffff;
    sendReq(8'h00, 8'h5e, 1'b0);
    chkRsp(8'h5e, 8'h12);
    rdChk(spif_pkg::ADDR_OUTIMG, 32'h12c0);
    rdChk(spif_pkg::ADDR_IRQST, 32'hd);
    test_done();
  end
endmodule : tb_top
